// >>> include/isrp_cfg.svh
// constants of the two-wire register port: bus address, offsets, reset values
// assumes: included by bare name from the design files, after the package
// Notes on behaviour
// (RL1) slave only, never drives the clock
// (RL2) data moves only while clock low
// (RL3) data fall, clock high: start, take address
// (RL4) data rise, clock high: stop, end transfer
// (RL5) transmitter releases, receiver pulls low on ninth
// (RL6) received bits sampled on rising clock edge
// (RL7) address byte MSB first, upper seven match
// (RL8) address LSB one reads, zero writes
// (RL9) acknowledge address only on a match
// (RL10) byte after write address loads sub-address
// (RL11) single write: one byte stored, acknowledged, stop
// (RL12) multibyte write stores at successive addresses
// (RL13) address counter steps after each byte
// (RL14) current-address read returns register at counter
// (RL15) master acknowledge sends next consecutive register
// (RL16) master withholds acknowledge, device releases line
// (RL17) registers are eight bits, whole bytes only
// (RL18) registers without reset value hold undefined value
// (RL19) random read: sub-address write, repeated start, read
// (RL20) master avoids reserved and read-only writes
`ifndef ISRP_CFG_SVH
`define ISRP_CFG_SVH

// ***************************************************************
// bus address and byte framing
// ***************************************************************
`define ISRP_DEV_ADDR 7'h43
`define ISRP_LAST_BIT 3'h7

// ***************************************************************
// register offsets
// ***************************************************************
`define ISRP_OFF_VERSION 8'h00
`define ISRP_OFF_IDENT 8'h01
`define ISRP_OFF_SYNTH_CTL 8'h05
`define ISRP_OFF_SYNTH_MUL 8'h06
`define ISRP_OFF_SYNTH_DIV 8'h07
`define ISRP_OFF_REQUEST_LINE_POLARITY 8'h0C
`define ISRP_OFF_EDGE_SEL 8'h0D
`define ISRP_OFF_FAULT 8'h0F
`define ISRP_OFF_SOFT_RST 8'h10
`define ISRP_OFF_PLAYBACK_CONTROL 8'h13
`define ISRP_OFF_SILENCE 8'h14
`define ISRP_OFF_CMD_IRQ 8'h16
`define ISRP_OFF_REQ_EN 8'h18
`define ISRP_OFF_SYNC 8'h40
`define ISRP_OFF_ANC_LO 8'h41
`define ISRP_OFF_ANC_HI 8'h42

// ***************************************************************
// reset values
// ***************************************************************
`define ISRP_RST_SYNTH_CTL 8'hA1
`define ISRP_RST_SYNTH_MUL 8'h0C
`define ISRP_RST_SYNTH_DIV 8'h00
`define ISRP_RST_REQUEST_LINE_POLARITY 8'h01
`define ISRP_RST_UNDEF 8'h00
`define ISRP_RST_PLAYBACK_CONTROL 8'h01
`define ISRP_RST_SILENCE 8'h00
`define ISRP_RST_CMD_IRQ 8'h00
`define ISRP_RST_REQ_EN 8'h00
`define ISRP_RD_NONE 8'h00

`endif

// >>> include/isrp_pkg.sv
// types of the two-wire register port
// assumes: compiled before the design files
package isrp_pkg;

  // protocol engine states
  typedef enum logic [3:0] {
    S_IDLE      = 4'h0,
    S_ADDR      = 4'h1,
    S_ADDR_ACK  = 4'h2,
    S_SUB       = 4'h3,
    S_SUB_ACK   = 4'h4,
    S_WDATA     = 4'h5,
    S_WDATA_ACK = 4'h6,
    S_RDATA     = 4'h7,
    S_RACK      = 4'h8
  } isrp_state_e;

  // writable registers as seen by the decoder core
  typedef struct packed {
    logic [7:0] synthControl;
    logic [7:0] synthMultiplier;
    logic [7:0] synthInputDivider;
    logic [7:0] requestLinePolarity;
    logic [7:0] inputClockEdgeSelect;
    logic [7:0] playbackControl;
    logic [7:0] outputSilenceControl;
    logic [7:0] commandInterruptControl;
    logic [7:0] requestLineEnable;
  } isrp_ctrl_s;

  // read-only state reported by the decoder core
  typedef struct packed {
    logic [7:0] lastFaultCode;
    logic [7:0] frameSyncState;
    logic [7:0] ancillaryCountLow;
    logic [7:0] ancillaryCountHigh;
  } isrp_status_s;

  // one queued register write
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } isrp_wr_s;

endpackage : isrp_pkg

// >>> rtl/isrp_slave_port.sv
// two-wire slave port with its write queue and register file
// assumes: clock and data pins are asynchronous to mclk, open-drain data
// wire resolved outside, decoder core on mclk supplies status
`timescale 1ns/10ps
`default_nettype none
`include "isrp_cfg.svh"

// ***************************************************************
// write queue, valid/ready on both sides
// ***************************************************************
module isrp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;
  logic [AW:0] count_reg, count_next;
  logic push, pop;

  // handshakes, full and empty from the fill count
  assign inReady = (count_reg != (AW + 1)'(DEPTH));
  assign outValid = (count_reg != '0);
  assign outData = mem[rdPtr_reg];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  // pointer and count next values; depth must be a power of two
  always_comb
  begin
    wrPtr_next = push ? wrPtr_reg + 1'b1 : wrPtr_reg;
    rdPtr_next = pop ? rdPtr_reg + 1'b1 : rdPtr_reg;
    count_next = count_reg;
    if (push && !pop)
      count_next = count_reg + 1'b1;
    else if (pop && !push)
      count_next = count_reg - 1'b1;
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      wrPtr_reg <= wrPtr_next;
      rdPtr_reg <= rdPtr_next;
      count_reg <= count_next;
    end
  end

  // storage carries data only, no reset needed
  always_ff @(posedge mclk)
  begin
    if (push)
      mem[wrPtr_reg] <= inData;
  end
endmodule : isrp_fifo

// ***************************************************************
// slave port top
// ***************************************************************
module isrp_slave_port #(
  parameter logic [7:0] SILICON_VERSION = 8'h00, // arbitrary value
  parameter logic [7:0] CHIP_IDENT = 8'h5A, // arbitrary value
  parameter int QUEUE_DEPTH = 8
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic sclPin,
  input wire logic sdaPin,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic cfgHold,
  input wire isrp_pkg::isrp_status_s status,
  output isrp_pkg::isrp_ctrl_s ctrl,
  output logic softResetPulse
);
  import isrp_pkg::*;

  logic sclMeta, sclS, sclD, sdaMeta, sdaS, sdaD;
  logic sclRise, sclFall, startEv, stopEv;
  isrp_state_e state_reg, state_next;
  logic [2:0] bitCnt_reg, bitCnt_next;
  logic [7:0] shift_reg, shift_next, addrCnt_reg, addrCnt_next, rdByte;
  logic ninth_reg, ninth_next, mAck_reg, mAck_next;
  logic sdaOe_reg, sdaOe_next, sdaOut_reg, pushNow;
  logic fifoInReady, fifoOutValid, applyWr;
  isrp_wr_s fifoOut;
  isrp_ctrl_s ctrl_reg, ctrl_next;
  logic softRst_reg, softRst_next;

  // ***************************************************************
  // pin synchronisers and bus events
  // ***************************************************************
  // two flops per pin, a third stage for edge finding
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      sclMeta <= 1'b1;
      sclS <= 1'b1;
      sclD <= 1'b1;
      sdaMeta <= 1'b1;
      sdaS <= 1'b1;
      sdaD <= 1'b1;
    end
    else
    begin
      sclMeta <= sclPin;
      sclS <= sclMeta;
      sclD <= sclS;
      sdaMeta <= sdaPin;
      sdaS <= sdaMeta;
      sdaD <= sdaS;
    end
  end

  // edges of the clock, start and stop while clock is high
  assign sclRise = sclS && !sclD;
  assign sclFall = !sclS && sclD;
  assign startEv = sclS && sclD && sdaD && !sdaS; // [RL3]
  assign stopEv = sclS && sclD && !sdaD && sdaS; // [RL4]

  // ***************************************************************
  // register read decode
  // ***************************************************************
  // whole bytes only; unmapped, reserved and write-only read as zero
  function automatic logic [7:0] regRead(input logic [7:0] a); // [RL17]
    logic [7:0] v;
    v = `ISRP_RD_NONE;
    unique case (a)
      `ISRP_OFF_VERSION: v = SILICON_VERSION;
      `ISRP_OFF_IDENT: v = CHIP_IDENT;
      `ISRP_OFF_SYNTH_CTL: v = ctrl_reg.synthControl;
      `ISRP_OFF_SYNTH_MUL: v = ctrl_reg.synthMultiplier;
      `ISRP_OFF_SYNTH_DIV: v = ctrl_reg.synthInputDivider;
      `ISRP_OFF_REQUEST_LINE_POLARITY: v = ctrl_reg.requestLinePolarity;
      `ISRP_OFF_EDGE_SEL: v = ctrl_reg.inputClockEdgeSelect;
      `ISRP_OFF_FAULT: v = status.lastFaultCode;
      `ISRP_OFF_PLAYBACK_CONTROL: v = ctrl_reg.playbackControl;
      `ISRP_OFF_SILENCE: v = ctrl_reg.outputSilenceControl;
      `ISRP_OFF_CMD_IRQ: v = ctrl_reg.commandInterruptControl;
      `ISRP_OFF_REQ_EN: v = ctrl_reg.requestLineEnable;
      `ISRP_OFF_SYNC: v = status.frameSyncState;
      `ISRP_OFF_ANC_LO: v = status.ancillaryCountLow;
      `ISRP_OFF_ANC_HI: v = status.ancillaryCountHigh;
      default: v = `ISRP_RD_NONE;
    endcase
    return v;
  endfunction : regRead

  assign rdByte = regRead(addrCnt_reg);

  // ***************************************************************
  // protocol engine
  // ***************************************************************
  // stop and start take priority; the line only moves on a clock fall
  always_comb
  begin
    state_next = state_reg;
    bitCnt_next = bitCnt_reg;
    shift_next = shift_reg;
    addrCnt_next = addrCnt_reg;
    ninth_next = ninth_reg;
    mAck_next = mAck_reg;
    sdaOe_next = sdaOe_reg;
    pushNow = 1'b0;
    if (stopEv)
    begin
      state_next = S_IDLE; // [RL4]
      sdaOe_next = 1'b0;
    end
    else if (startEv)
    begin
      state_next = S_ADDR; // [RL3]
      bitCnt_next = 3'h0;
      sdaOe_next = 1'b0;
    end
    else if (sclRise)
    begin
      unique case (state_reg)
        S_ADDR, S_SUB, S_WDATA:
        begin
          shift_next = {shift_reg[6:0], sdaS}; // [RL6] [RL7]
          bitCnt_next = bitCnt_reg + 3'h1;
          if (bitCnt_reg == `ISRP_LAST_BIT)
          begin
            ninth_next = 1'b0;
            state_next = (state_reg == S_ADDR) ? S_ADDR_ACK :
                         (state_reg == S_SUB) ? S_SUB_ACK : S_WDATA_ACK;
          end
        end
        S_ADDR_ACK, S_SUB_ACK, S_WDATA_ACK:
          ninth_next = 1'b1;
        S_RDATA:
        begin
          bitCnt_next = bitCnt_reg + 3'h1;
          if (bitCnt_reg == `ISRP_LAST_BIT)
          begin
            state_next = S_RACK;
            ninth_next = 1'b0;
          end
        end
        S_RACK:
        begin
          ninth_next = 1'b1;
          mAck_next = !sdaS; // master acknowledge on ninth pulse
        end
        S_IDLE: ;
        default: state_next = S_IDLE;
      endcase
    end
    else if (sclFall) // [RL2]
    begin
      unique case (state_reg)
        S_ADDR_ACK:
          if (!ninth_reg)
          begin
            if (shift_reg[7:1] == `ISRP_DEV_ADDR)
              sdaOe_next = 1'b1; // [RL9] [RL5]
            else
              state_next = S_IDLE; // [RL9]
          end
          else
          begin
            bitCnt_next = 3'h0;
            if (shift_reg[0]) // [RL8]
            begin
              state_next = S_RDATA; // [RL14]
              shift_next = rdByte;
              sdaOe_next = !rdByte[7];
            end
            else
            begin
              state_next = S_SUB;
              sdaOe_next = 1'b0;
            end
          end
        S_SUB_ACK:
          if (!ninth_reg)
          begin
            sdaOe_next = 1'b1;
            addrCnt_next = shift_reg; // [RL10]
          end
          else
          begin
            sdaOe_next = 1'b0;
            bitCnt_next = 3'h0;
            state_next = S_WDATA;
          end
        S_WDATA_ACK:
          if (!ninth_reg)
          begin
            if (fifoInReady)
            begin
              pushNow = 1'b1; // [RL11] [RL12]
              sdaOe_next = 1'b1;
              addrCnt_next = addrCnt_reg + 8'h01; // [RL13]
            end
            else
              state_next = S_IDLE; // queue full: byte refused
          end
          else
          begin
            sdaOe_next = 1'b0;
            bitCnt_next = 3'h0;
            state_next = S_WDATA;
          end
        S_RDATA:
        begin
          shift_next = {shift_reg[6:0], 1'b0};
          sdaOe_next = !shift_reg[6];
        end
        S_RACK:
          if (!ninth_reg)
          begin
            sdaOe_next = 1'b0; // [RL5]
            addrCnt_next = addrCnt_reg + 8'h01; // [RL13]
          end
          else if (mAck_reg)
          begin
            state_next = S_RDATA; // [RL15]
            bitCnt_next = 3'h0;
            shift_next = rdByte;
            sdaOe_next = !rdByte[7];
          end
          else
            state_next = S_IDLE; // [RL16]
        S_IDLE, S_ADDR, S_SUB, S_WDATA: ;
        default: state_next = S_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= S_IDLE;
      bitCnt_reg <= 3'h0;
      shift_reg <= 8'h00;
      addrCnt_reg <= 8'h00;
      ninth_reg <= 1'b0;
      mAck_reg <= 1'b0;
      sdaOe_reg <= 1'b0;
      sdaOut_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      bitCnt_reg <= bitCnt_next;
      shift_reg <= shift_next;
      addrCnt_reg <= addrCnt_next;
      ninth_reg <= ninth_next;
      mAck_reg <= mAck_next;
      sdaOe_reg <= sdaOe_next;
      sdaOut_reg <= 1'b0; // open drain: only ever pulls low [RL1]
    end
  end

  assign sdaOe = sdaOe_reg;
  assign sdaOut = sdaOut_reg;

  // ***************************************************************
  // write queue and register file
  // ***************************************************************
  isrp_fifo #(
    .WIDTH($bits(isrp_wr_s)),
    .DEPTH(QUEUE_DEPTH)
  ) u_queue (
    .mclk(mclk),
    .resetn(resetn),
    .inValid(pushNow),
    .inData({addrCnt_reg, shift_reg}),
    .inReady(fifoInReady),
    .outValid(fifoOutValid),
    .outData(fifoOut),
    .outReady(!cfgHold)
  );

  assign applyWr = fifoOutValid && !cfgHold;

  // drained writes update writable registers; read-only ones ignore them
  always_comb
  begin
    ctrl_next = ctrl_reg;
    softRst_next = 1'b0;
    if (applyWr)
    begin
      unique case (fifoOut.addr)
        `ISRP_OFF_SYNTH_CTL: ctrl_next.synthControl = fifoOut.data;
        `ISRP_OFF_SYNTH_MUL: ctrl_next.synthMultiplier = fifoOut.data;
        `ISRP_OFF_SYNTH_DIV: ctrl_next.synthInputDivider = fifoOut.data;
        `ISRP_OFF_REQUEST_LINE_POLARITY: ctrl_next.requestLinePolarity = fifoOut.data;
        `ISRP_OFF_EDGE_SEL: ctrl_next.inputClockEdgeSelect = fifoOut.data;
        `ISRP_OFF_SOFT_RST: softRst_next = 1'b1;
        `ISRP_OFF_PLAYBACK_CONTROL: ctrl_next.playbackControl = fifoOut.data;
        `ISRP_OFF_SILENCE: ctrl_next.outputSilenceControl = fifoOut.data;
        `ISRP_OFF_CMD_IRQ: ctrl_next.commandInterruptControl = fifoOut.data;
        `ISRP_OFF_REQ_EN: ctrl_next.requestLineEnable = fifoOut.data;
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_reg.synthControl <= `ISRP_RST_SYNTH_CTL;
      ctrl_reg.synthMultiplier <= `ISRP_RST_SYNTH_MUL;
      ctrl_reg.synthInputDivider <= `ISRP_RST_SYNTH_DIV;
      ctrl_reg.requestLinePolarity <= `ISRP_RST_REQUEST_LINE_POLARITY;
      ctrl_reg.inputClockEdgeSelect <= `ISRP_RST_UNDEF; // [RL18]
      ctrl_reg.playbackControl <= `ISRP_RST_PLAYBACK_CONTROL;
      ctrl_reg.outputSilenceControl <= `ISRP_RST_SILENCE;
      ctrl_reg.commandInterruptControl <= `ISRP_RST_CMD_IRQ;
      ctrl_reg.requestLineEnable <= `ISRP_RST_REQ_EN;
      softRst_reg <= 1'b0;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      softRst_reg <= softRst_next;
    end
  end

  assign ctrl = ctrl_reg;
  assign softResetPulse = softRst_reg;

  // ***************************************************************
  // checks
  // ***************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  slave_only_a: assert property (sdaOe |-> // [RL1]
    state_reg inside {S_ADDR_ACK, S_SUB_ACK, S_WDATA_ACK, S_RDATA, S_RACK})
    else $error("data line driven outside own turn");
  sda_move_a: assert property ($changed(sdaOe) |-> !$past(sclS)) // [RL2]
    else $error("data line moved while clock high");
  start_addr_a: assert property (startEv && !stopEv |=> // [RL3]
    state_reg == S_ADDR && bitCnt_reg == 3'h0 && !sdaOe)
    else $error("start not followed by address reception");
  stop_idle_a: assert property (stopEv |=> // [RL4]
    state_reg == S_IDLE && !sdaOe)
    else $error("stop did not end the transfer");
  sub_ack_a: assert property (state_reg == S_SUB_ACK && ninth_reg // [RL5]
    |-> sdaOe)
    else $error("sub-address not acknowledged");
  rise_sample_a: assert property (sclRise && !startEv && !stopEv && // [RL6]
    state_reg inside {S_ADDR, S_SUB, S_WDATA} |=> shift_reg[0] == $past(sdaS))
    else $error("bit not taken on rising clock");
  addr_miss_a: assert property (sclFall && state_reg == S_ADDR_ACK && // [RL9]
    !ninth_reg && shift_reg[7:1] != `ISRP_DEV_ADDR
    |=> state_reg == S_IDLE && !sdaOe)
    else $error("foreign address acknowledged");
  sub_load_a: assert property (sclFall && state_reg == S_SUB_ACK && // [RL10]
    !ninth_reg |=> addrCnt_reg == $past(shift_reg))
    else $error("sub-address not loaded");
  count_step_a: assert property (sclFall && !startEv && !stopEv && // [RL13]
    state_reg == S_RACK && !ninth_reg |=> addrCnt_reg == $past(addrCnt_reg) + 8'h01)
    else $error("address counter did not step after read");
  nack_end_a: assert property (sclFall && state_reg == S_RACK && // [RL16]
    ninth_reg && !mAck_reg |=> state_reg == S_IDLE && !sdaOe)
    else $error("read continued after missing acknowledge");

  write_cv: cover property (pushNow);
  read_more_cv: cover property (sclFall && state_reg == S_RACK && ninth_reg
    && mAck_reg);
  queue_full_cv: cover property (!fifoInReady);
  soft_rst_cv: cover property (softResetPulse);
endmodule : isrp_slave_port

`default_nettype wire

// >>> sim/i2c_slave_register_port_tb.sv
// self-checking bench of the two-wire register port
// assumes: package, design files and the bus master model compiled first
`timescale 1ns/10ps
`default_nettype none
`include "isrp_cfg.svh"
module i2c_slave_register_port_tb;
  import isrp_pkg::*;
  localparam logic [7:0] IDENT_VAL = 8'h3C; // arbitrary value
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic cfgHold = 1'b0;
  isrp_status_s status = '0;
  isrp_ctrl_s ctrl;
  logic sdaOut, sdaOe, softResetPulse, scl, sdaLow, seenStrobe;
  logic [7:0] seenData, ptr;
  logic [7:0] shadow [256];
  logic dc [256];
  logic [8:0] expQ [$];
  logic [15:0] lfsr = 16'h81DE;
  int errors = 0, checks_done = 0, cycles = 0, pulses = 0;
  wire logic sdaLine = ~(sdaLow | (sdaOe & ~sdaOut)); // pull-up wire
  isrp_slave_port #(.CHIP_IDENT(IDENT_VAL)) dut (.mclk(mclk),
    .resetn(resetn), .sclPin(scl), .sdaPin(sdaLine), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .cfgHold(cfgHold), .status(status), .ctrl(ctrl),
    .softResetPulse(softResetPulse));
  isrp_bus_master m (.scl(scl), .sdaLow(sdaLow), .sda(sdaLine),
    .seenStrobe(seenStrobe), .seenData(seenData));
  // ****************************************************************
  // clock, checking, monitors
  // ****************************************************************
  initial
  begin
    forever #2.5 mclk = ~mclk;
  end
  task automatic check(input logic [71:0] seen, input logic [71:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test();
    if (errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  // oldest note against each byte or acknowledge the master reports; notes marked don't-care are not checked
  always @(posedge seenStrobe)
  begin : mon
    logic [8:0] e;
    e = expQ.pop_front();
    if (!e[8])
      check(seenData, e[7:0]);
  end
  always @(sdaOe)
    if (resetn === 1'b1)
      check(scl, 1'b0);
  always @(negedge mclk)
  begin
    cycles++;
    if (softResetPulse === 1'b1)
      pulses++;
    if (cycles == 40000)
    begin
      errors++;
      finish_test();
    end
  end
  // ****************************************************************
  // stimulus helpers
  // ****************************************************************
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr[7:0];
  endfunction : rnd
  function automatic logic isRw(input logic [7:0] a);
    return a inside {8'h05, 8'h06, 8'h07, 8'h0C, 8'h0D, 8'h13, 8'h14,
      8'h16, 8'h18};
  endfunction : isRw
  function automatic logic isDoc(input logic [7:0] a);
    return a inside {8'h00, 8'h01, 8'h05, 8'h06, 8'h07, 8'h0C, 8'h0D, 8'h0F,
      8'h10, 8'h13, 8'h14, 8'h16, 8'h18, 8'h40, 8'h41, 8'h42};
  endfunction : isDoc
  function automatic isrp_ctrl_s expCtrl();
    return {shadow[8'h05], shadow[8'h06], shadow[8'h07], shadow[8'h0C],
      shadow[8'h0D], shadow[8'h13], shadow[8'h14], shadow[8'h16],
      shadow[8'h18]};
  endfunction : expCtrl
  task automatic checkCtrl(input isrp_ctrl_s e);
    logic [71:0] mk;
    mk = '1;
    if (dc[8'h0D])
      mk[39:32] = 8'h00; // edge select has no defined reset value
    check(ctrl & mk, e & mk);
  endtask : checkCtrl
  task automatic tx(input logic [7:0] b, input logic ack);
    expQ.push_back({1'b0, 7'h00, ack});
    m.sendByte(b);
  endtask : tx
  task automatic rx(input logic [7:0] a, input logic more);
    expQ.push_back({dc[a], shadow[a]});
    m.recvByte(more);
  endtask : rx
  task automatic wrBurst(input logic [7:0] sub, input int n, input int nAck);
    logic [7:0] d;
    ptr = sub;
    m.start();
    tx({`ISRP_DEV_ADDR, 1'b0}, 1'b0);
    tx(sub, 1'b0);
    for (int i = 0; i < n; i++)
    begin
      d = rnd();
      tx(d, i >= nAck);
      if (i < nAck && isRw(ptr))
        shadow[ptr] = d;
      if (i < nAck)
        dc[ptr] = 1'b0;
      ptr++;
    end
    m.stop();
  endtask : wrBurst
  task automatic rdBurst(input logic [7:0] sub, input int n, input logic viaSub);
    if (viaSub)
    begin
      m.start();
      tx({`ISRP_DEV_ADDR, 1'b0}, 1'b0);
      tx(sub, 1'b0);
      ptr = sub;
    end
    m.start();
    tx({`ISRP_DEV_ADDR, 1'b1}, 1'b0);
    for (int i = 0; i < n; i++)
    begin
      rx(ptr, i < n - 1);
      ptr++; // counter steps after each byte, wrapping at the top
    end
    m.stop();
    check(sdaOe, 1'b0);
  endtask : rdBurst
  // sequential reads over each run of documented registers only
  task automatic rdDoc();
    int n;
    for (int a = 0; a < 256; a++)
      if (isDoc(8'(a)) && !isDoc(8'(a - 1)))
      begin
        n = 1;
        while (isDoc(8'(a + n)))
          n++;
        rdBurst(8'(a), n, 1'b1);
      end
  endtask : rdDoc
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    isrp_ctrl_s held;
    for (int i = 0; i < 256; i++)
    begin
      shadow[i] = 8'h00; // unmapped, reserved, write-only read as zero
      dc[i] = 1'b0;
    end
    shadow[8'h01] = IDENT_VAL;
    shadow[8'h05] = 8'hA1;
    shadow[8'h06] = 8'h0C;
    shadow[8'h0C] = 8'h01;
    shadow[8'h13] = 8'h01;
    dc[8'h00] = 1'b1;
    dc[8'h0D] = 1'b1;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    resetn = 1'b1;
    status = {rnd(), rnd(), rnd(), rnd()};
    {shadow[8'h0F], shadow[8'h40], shadow[8'h41], shadow[8'h42]} = status;
    repeat (3) @(negedge mclk);
    checkCtrl(expCtrl());
    check(sdaOe, 1'b0);
    rdDoc();
    rdBurst(8'h40, 3, 1'b1);
    // every single-bit corruption of the device address is ignored
    for (int k = 0; k < 7; k++)
    begin
      m.start();
      tx({`ISRP_DEV_ADDR ^ (7'h01 << k), 1'b0}, 1'b1);
      m.stop();
    end
    wrBurst(8'h16, 1, 1);
    wrBurst(8'h0C, 2, 2);
    wrBurst(8'h05, 2, 2);
    checkCtrl(expCtrl());
    ptr = 8'h07;
    rdBurst(8'h00, 1, 1'b0); // current address read
    wrBurst(8'h10, 1, 1);
    check(pulses, 1);
    rdBurst(8'h0F, 2, 1'b1);
    // hold the drain, fill the queue until a byte is refused
    held = expCtrl();
    @(negedge mclk);
    cfgHold = 1'b1;
    m.stall = 40;
    wrBurst(8'h05, 3, 3);
    wrBurst(8'h0C, 2, 2);
    wrBurst(8'h13, 2, 2);
    wrBurst(8'h16, 1, 1);
    wrBurst(8'h18, 1, 0); // ninth queued byte is refused
    checkCtrl(held);
    @(negedge mclk);
    cfgHold = 1'b0;
    m.stall = 0;
    for (int w = 0; w < 50 && ctrl !== expCtrl(); w++)
      @(negedge mclk);
    checkCtrl(expCtrl());
    rdDoc();
    rdBurst(8'h05, 3, 1'b1);
    check(pulses, 1);
    finish_test();
  end
endmodule : i2c_slave_register_port_tb
`default_nettype wire

// >>> sim/isrp_bus_master.sv
// bus master model for the two-wire register port, drives clock and data
// assumes: the bench resolves the data wire with a pull-up
`timescale 1ns/10ps
`default_nettype none
module isrp_bus_master (
  output logic scl,
  output logic sdaLow,
  input wire logic sda,
  output logic seenStrobe,
  output logic [7:0] seenData
);
  // ****************************************************************
  // pin timing, 64 ns bus clock, stalls stretch the low phase
  // ****************************************************************
  int quarter = 16;
  int stall = 0;
  initial
  begin
    scl = 1'b1; // clock stands high between frames
    sdaLow = 1'b0;
    seenStrobe = 1'b0;
    seenData = 8'h00;
  end
  // one bit: data set while clock low, sampled just before the fall
  task automatic bitIo(input logic b, output logic r);
    sdaLow = ~b;
    #(quarter + stall);
    scl = 1'b1;
    #(2 * quarter);
    r = sda;
    scl = 1'b0;
    #quarter;
  endtask : bitIo
  task automatic start();
    sdaLow = 1'b0;
    #quarter;
    scl = 1'b1;
    #quarter;
    sdaLow = 1'b1;
    #quarter;
    scl = 1'b0;
    #quarter;
  endtask : start
  task automatic stop();
    sdaLow = 1'b1;
    #quarter;
    scl = 1'b1;
    #quarter;
    sdaLow = 1'b0;
    #(2 * quarter);
  endtask : stop
  // hands a finished result to the bench monitor
  task automatic report(input logic [7:0] v);
    seenData = v;
    seenStrobe = 1'b1;
    #1 seenStrobe = 1'b0;
  endtask : report
  task automatic sendByte(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitIo(b[i], r);
    bitIo(1'b1, r);
    report({7'h00, r});
  endtask : sendByte
  task automatic recvByte(input logic ack);
    logic [7:0] d;
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bitIo(1'b1, r);
      d[i] = r;
    end
    bitIo(~ack, r);
    report(d);
  endtask : recvByte
endmodule : isrp_bus_master
`default_nettype wire
